//--- hw/i2c_bus_sampler.sv
`timescale 1ns/1ps
module i2c_bus_sampler
	import i2c_slave_pkg::*;
(
	input  wire logic     sys_clk,
	input  wire logic     sys_rst,
	input  wire logic     scl_in,
	input  wire logic     sda_in,
	output bus_evt_s      evt
);
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_prev;
	logic       sda_prev;

	// Two stages before any decision; third stage is the edge reference
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end
		else
		begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
		end
	end

	assign evt.scl      = scl_sync[1];
	assign evt.sda      = sda_sync[1];
	assign evt.scl_rise = scl_sync[1] & ~scl_prev;
	assign evt.scl_fall = ~scl_sync[1] & scl_prev;
	assign evt.start    = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
	assign evt.stop     = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
endmodule

//--- hw/i2c_slave_hold.sv
`timescale 1ns/1ps
`include "i2c_slave_regs.svh"
module i2c_slave_hold
	import i2c_slave_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            scl_oe_n,
	output logic            sda_oe_n,
	output logic            scl_out,
	output logic            sda_out,
	input  wire sw_ctrl_s   ctrl,
	input  wire sw_cfg_s    cfg,
	output logic [7:0]      data_buffer,
	output logic [7:0]      own_address_reg,
	output logic            serial_irq_flag,
	output logic            clock_release,
	output logic            ack_time_status,
	output logic            ack_received_status,
	output logic            buffer_full,
	output logic            update_address_flag,
	output logic            bus_collision_flag,
	output logic            receive_overflow,
	output logic            read_write_status,
	output logic            data_not_address,
	output logic            start_seen,
	output logic            stop_seen
);
	bus_evt_s     evt;
	slave_state_e state;
	slave_state_e next_state;
	logic [7:0]   shift_register;
	logic [3:0]   bit_count;
	logic         ack_phase;
	logic         ack_drive;
	logic         stretch_req;
	logic         ten_matched;
	logic         drive_low_sda;

	i2c_bus_sampler u_sampler
	(
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.evt     (evt)
	);

	// ***********************************************************
	// Decode
	// ***********************************************************
	wire [7:0] rx_byte   = {shift_register[6:0], evt.sda};
	wire       edge8     = evt.scl_fall & (bit_count == `BYTE_BITS);
	wire       edge9     = evt.scl_fall & (bit_count == `ACK_SLOT);
	wire       rise9     = evt.scl_rise & (bit_count == `BYTE_BITS);
	wire       rise_bit  = evt.scl_rise & (bit_count < `BYTE_BITS);
	wire       blocked   = buffer_full | receive_overflow;
	wire       match7    = (shift_register[7:1] == own_address_reg[7:1]);
	wire       match_hi  = (shift_register[7:3] == `TEN_BIT_HDR) &
		(shift_register[2:1] == own_address_reg[2:1]);
	wire       match_lo  = (shift_register == own_address_reg);
	wire       addr_hit  = cfg.ten_bit_mode ? match_hi : match7;
	wire       rd_bit    = shift_register[0];
	wire       is_rx     = (state == ST_ADDR) | (state == ST_ADDR_LO) |
		(state == ST_RX);
	wire       hit_now   = (state == ST_ADDR) ? addr_hit :
		(state == ST_ADDR_LO) ? match_lo : 1'b1;
	wire       hold_on   = (state == ST_RX) ? cfg.data_hold_enable :
		cfg.address_hold_enable;
	wire       auto_ack  = ~blocked & hit_now;
	wire       ack_level = hold_on ? cfg.ack_data_value : 1'b0;
	// Ten-bit read only valid after a full write match
	wire       rd_ok     = ~cfg.ten_bit_mode | ten_matched;
	wire       collide   = (state == ST_TX) & evt.scl_rise &
		(bit_count < `BYTE_BITS) & shift_register[7] & ~evt.sda;

	// ***********************************************************
	// Sequencer
	// ***********************************************************
	always_comb
	begin
		next_state = state;
		if (evt.start)
			next_state = ST_ADDR;
		else if (evt.stop)
			next_state = ST_IDLE;
		else if (collide & cfg.slave_collision_detect_enable)
			next_state = ST_IDLE;
		else if (edge8 & (state == ST_ADDR) & ~addr_hit)
			next_state = ST_IDLE;
		else if (edge9 & ack_drive)
			next_state = ST_IDLE;
		else if (edge9 & (state == ST_ADDR))
		begin
			if (cfg.ten_bit_mode & ~rd_bit)
				next_state = ST_ADDR_LO;
			else if (rd_bit)
				next_state = ST_TX;
			else
				next_state = ST_RX;
		end
		else if (edge9 & (state == ST_ADDR_LO))
			next_state = ST_RX;
		else if (edge9 & (state == ST_TX) & ack_received_status)
			next_state = ST_IDLE;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// ***********************************************************
	// Bit counter and shifter
	// ***********************************************************
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bit_count      <= 4'h0;
			shift_register <= `BUF_RESET;
		end
		else if (evt.start)
		begin
			bit_count      <= 4'h0;
			shift_register <= `BUF_RESET;
		end
		else if (ctrl.buf_write & (state == ST_TX))
			shift_register <= ctrl.buf_wdata;
		else
		begin
			if (rise_bit & is_rx)
				shift_register <= rx_byte;
			if (evt.scl_fall & (state == ST_TX) & (bit_count != 4'h0) &
				(bit_count < `BYTE_BITS))
				shift_register <= {shift_register[6:0], 1'b1};
			if (evt.scl_rise)
				bit_count <= bit_count + 4'h1;
			else if (edge9)
				bit_count <= 4'h0;
		end
	end

	// ***********************************************************
	// Ack decision, taken at edge eight
	// ***********************************************************
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ack_drive   <= 1'b1;
			ack_phase   <= 1'b0;
		end
		else if (evt.start | evt.stop)
		begin
			ack_drive   <= 1'b1;
			ack_phase   <= 1'b0;
		end
		else if (edge8 & is_rx)
		begin
			ack_phase   <= 1'b1;
			ack_drive   <= ~auto_ack | ack_level;
		end
		else if (hold_on & ack_phase & stretch_req)
			// Software may still change its choice while held
			ack_drive   <= ~auto_ack | cfg.ack_data_value;
		else if (edge9)
			ack_phase   <= 1'b0;
	end

	// SDA: ack slot in receive, data bits in transmit
	assign drive_low_sda = (ack_phase & ~ack_drive & is_rx) |
		((state == ST_TX) & ((bit_count < `BYTE_BITS) |
		((bit_count == `BYTE_BITS) & evt.scl)) &
		~shift_register[7] & ~ack_phase);

	// ***********************************************************
	// Status and stretch
	// ***********************************************************
	wire hold8    = edge8 & is_rx & hold_on & hit_now &
		(cfg.address_hold_enable | cfg.data_hold_enable);
	wire acked9   = edge9 & is_rx & ~ack_drive;
	wire hi_done  = acked9 & (state == ST_ADDR) & cfg.ten_bit_mode &
		~rd_bit;
	wire lo_done  = edge9 & (state == ST_ADDR_LO);
	wire rd_done  = acked9 & (state == ST_ADDR) & rd_bit & rd_ok;
	wire tx_done  = edge9 & (state == ST_TX);
	wire rx_stash = rise9 & is_rx & ~ack_drive;

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			serial_irq_flag     <= 1'b0;
			clock_release       <= 1'b1;
			stretch_req         <= 1'b0;
			ack_time_status     <= 1'b0;
			ack_received_status <= 1'b0;
			buffer_full         <= 1'b0;
			update_address_flag <= 1'b0;
			bus_collision_flag  <= 1'b0;
			receive_overflow    <= 1'b0;
			read_write_status   <= 1'b0;
			data_not_address    <= 1'b0;
			start_seen          <= 1'b0;
			stop_seen           <= 1'b0;
			ten_matched         <= 1'b0;
			data_buffer         <= `BUF_RESET;
			own_address_reg     <= `ADDR_RESET;
		end
		else
		begin
			// Set wins over software clear throughout
			if (hold8 | acked9 | lo_done | tx_done)
				serial_irq_flag <= 1'b1;
			else if (ctrl.irq_clear)
				serial_irq_flag <= 1'b0;
			if (hold8)
			begin
				clock_release <= 1'b0;
				stretch_req   <= 1'b1;
			end
			else if (rd_done | (acked9 & cfg.stretch_enable & ~hi_done))
			begin
				clock_release <= 1'b0;
				stretch_req   <= 1'b1;
			end
			else if (tx_done & ~ack_received_status)
			begin
				clock_release <= 1'b0;
				stretch_req   <= 1'b1;
			end
			else if (ctrl.release_set)
			begin
				clock_release <= 1'b1;
				stretch_req   <= 1'b0;
			end
			if (evt.start | evt.stop)
				ack_time_status <= 1'b0;
			else if (hold8)
				ack_time_status <= 1'b1;
			else if (edge9)
				ack_time_status <= 1'b0;
			if (rise9 & (state == ST_TX))
				ack_received_status <= evt.sda;
			if (hi_done | lo_done)
				update_address_flag <= 1'b1;
			else if (ctrl.addr_write)
				update_address_flag <= 1'b0;
			if (ctrl.addr_write & ~ack_phase)
				own_address_reg <= ctrl.addr_wdata;
			if (collide & cfg.slave_collision_detect_enable)
				bus_collision_flag <= 1'b1;
			else if (ctrl.bcol_clear)
				bus_collision_flag <= 1'b0;
			if (rise9 & is_rx & blocked & ~(state == ST_ADDR_LO & ~match_lo))
				receive_overflow <= 1'b1;
			else if (ctrl.ovf_clear)
				receive_overflow <= 1'b0;
			if (rx_stash)
			begin
				data_buffer <= shift_register;
				buffer_full <= 1'b1;
			end
			else if (ctrl.buf_write & (state == ST_TX))
			begin
				data_buffer <= ctrl.buf_wdata;
				buffer_full <= 1'b1;
			end
			else if (tx_done | ctrl.buf_read)
				buffer_full <= 1'b0;
			if (edge8 & (state == ST_ADDR) & addr_hit)
			begin
				read_write_status <= rd_bit;
				data_not_address  <= 1'b0;
			end
			else if (edge9 & (state == ST_RX))
				data_not_address  <= 1'b1;
			if (lo_done & match_lo & auto_ack)
				ten_matched <= 1'b1;
			else if (evt.stop | (edge8 & (state == ST_ADDR) &
				(~addr_hit | ~rd_bit)))
				ten_matched <= 1'b0;
			start_seen <= evt.start ? 1'b1 : (evt.stop ? 1'b0 : start_seen);
			stop_seen  <= evt.stop ? 1'b1 : (evt.start ? 1'b0 : stop_seen);
		end
	end

	// ***********************************************************
	// Pin drivers
	// ***********************************************************
	// Only grab SCL once sampled low, so no high phase is cut short
	wire upd_hold  = update_address_flag;
	wire scl_grab  = (stretch_req | upd_hold) & ~evt.scl;
	wire scl_keep  = (stretch_req | upd_hold) & ~scl_oe_n;

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			scl_out  <= 1'b1;
			sda_out  <= 1'b1;
		end
		else
		begin
			scl_oe_n <= ~(scl_grab | scl_keep);
			sda_oe_n <= ~drive_low_sda | (state == ST_IDLE);
			scl_out  <= 1'b0;
			sda_out  <= 1'b0;
		end
	end
endmodule

//--- hw/i2c_slave_pkg.sv
package i2c_slave_pkg;
	typedef enum logic [2:0]
	{
		ST_IDLE    = 3'b000,
		ST_ADDR    = 3'b001,
		ST_ADDR_LO = 3'b010,
		ST_RX      = 3'b011,
		ST_TX      = 3'b100
	} slave_state_e;

	// Local software strobes
	typedef struct packed
	{
		logic       buf_read;
		logic       buf_write;
		logic [7:0] buf_wdata;
		logic       addr_write;
		logic [7:0] addr_wdata;
		logic       release_set;
		logic       irq_clear;
		logic       bcol_clear;
		logic       ovf_clear;
	} sw_ctrl_s;

	// Mode configuration levels
	typedef struct packed
	{
		logic address_hold_enable;
		logic data_hold_enable;
		logic stretch_enable;
		logic ten_bit_mode;
		logic slave_collision_detect_enable;
		logic ack_data_value;
	} sw_cfg_s;

	// Bus events found by sampling
	typedef struct packed
	{
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic scl;
		logic sda;
	} bus_evt_s;
endpackage

//--- hw/i2c_slave_regs.svh
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH
// Byte bit count, ack slot index
`define BYTE_BITS      4'h8
`define ACK_SLOT       4'h9
// 10-bit high address pattern, upper five bits
`define TEN_BIT_HDR    5'h1e
`define BUF_RESET      8'h00
`define ADDR_RESET     8'h00
`endif

//--- tb/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model
(
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_m,
	output logic      sda_m
);
	// ****
	// Bus master, about 400 ns a bit
	// ****
	initial
	begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end
	// Odd high time keeps our edges off the sampling clock's edges
	task automatic bit_io(input logic b, output logic r);
	begin
		#100 sda_m = b;
		#200 scl_m = 1'b1;
		wait (scl === 1'b1);
		#57.3 r = sda;
		#45.4 scl_m = 1'b0;
	end
	endtask
	task automatic xfer(input logic [7:0] d, input logic a9,
		output logic [7:0] q, output logic r9);
	begin
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(a9, r9);
	end
	endtask
	task automatic start;
	begin
		#13 sda_m = 1'b0;
		#200 scl_m = 1'b0;
	end
	endtask
	task automatic stop;
	begin
		#100 sda_m = 1'b0;
		#200 scl_m = 1'b1;
		wait (scl === 1'b1);
		#203.1 sda_m = 1'b1;
		#500;
	end
	endtask
endmodule

//--- tb/i2c_slave_hold_assertions.sv
`timescale 1ns/1ps
module i2c_slave_hold_assertions
	import i2c_slave_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       scl_in,
	input wire logic       scl_oe_n,
	input wire logic       sda_oe_n,
	input wire sw_ctrl_s   ctrl,
	input wire logic [7:0] own_address_reg,
	input wire logic       serial_irq_flag,
	input wire logic       clock_release,
	input wire logic       buffer_full,
	input wire logic       update_address_flag,
	input wire logic       bus_collision_flag
);
	// ****
	// Port timing
	// ****
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	a_release_frees_scl:
	assert property ($rose(clock_release) |-> ##[1:3] scl_oe_n)
		else $error("scl held after release");
	a_hold_pulls_scl:
	assert property ($fell(clock_release) |-> ##[1:3] !scl_oe_n)
		else $error("scl not held after clear");
	a_pull_when_low:
	assert property ($fell(scl_oe_n) |-> !$past(scl_in))
		else $error("scl pulled while high");
	a_irq_flag_stands:
	assert property (serial_irq_flag && !ctrl.irq_clear |=> serial_irq_flag)
		else $error("irq flag dropped");
	a_load_sets_full:
	assert property (ctrl.buf_write |=> buffer_full)
		else $error("buffer full not set");
	a_addr_write_takes:
	assert property (ctrl.addr_write |=> own_address_reg ==
		$past(ctrl.addr_wdata) && !update_address_flag)
		else $error("address write lost");
	a_sda_moves_low:
	assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("sda moved with scl high");
	a_collision_idles:
	assert property ($rose(bus_collision_flag) |-> sda_oe_n [*8])
		else $error("sda driven after collision");
endmodule

//--- tb/i2c_slave_hold_bench.sv
`timescale 1ns/1ps
module i2c_slave_hold_bench
	import i2c_slave_pkg::*;
;
	logic       sys_clk, sys_rst, scl_m, sda_m, scl_oe_n, sda_oe_n, a;
	sw_ctrl_s   ctrl;
	sw_cfg_s    cfg;
	logic [7:0] data_buffer, own_address_reg, q;
	logic       serial_irq_flag, clock_release, ack_time_status;
	logic       ack_received_status, buffer_full, update_address_flag;
	logic       bus_collision_flag, read_write_status, stop_seen;
	logic       receive_overflow, data_not_address, start_seen;
	int         num_errors = 0;
	int         n_checks = 0;
	// Pull-ups: any low enable wins
	wire        scl = scl_m & scl_oe_n;
	wire        sda = sda_m & sda_oe_n;
	i2c_master_model m
	(
		.scl, .sda, .scl_m, .sda_m
	);
	i2c_slave_hold dut
	(
		.sys_clk, .sys_rst, .scl_in(scl), .sda_in(sda), .scl_oe_n,
		.sda_oe_n, .scl_out(), .sda_out(), .ctrl, .cfg, .data_buffer,
		.own_address_reg, .serial_irq_flag, .clock_release, .ack_time_status,
		.ack_received_status, .buffer_full, .update_address_flag,
		.bus_collision_flag, .receive_overflow, .read_write_status,
		.data_not_address, .start_seen, .stop_seen
	);
	// ****
	// Helpers
	// ****
	task automatic check(input string what, input logic [7:0] seen, exp);
	begin
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task automatic cycles(input int n);
	begin
		repeat (n) @(posedge sys_clk);
		#5;
	end
	endtask
	task automatic sw(input sw_ctrl_s c);
	begin
		@(posedge sys_clk);
		#5 ctrl = c;
		@(posedge sys_clk);
		#5 ctrl = '0;
	end
	endtask
	task automatic wait_irq;
		int n;
	begin
		n = 0;
		while (serial_irq_flag !== 1'b1 && n < 400)
		begin
			cycles(1);
			n++;
		end
	end
	endtask
	task automatic finish_test;
	begin
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	// ****
	// Scenarios
	// ****
	task automatic hold_byte(input logic [7:0] d, input logic nack);
	begin
		fork
			m.xfer(d, 1'b1, q, a);
			begin
				wait_irq();
				check("irq8", serial_irq_flag, 1'b1);
				check("release", clock_release, 1'b0);
				check("ack_time", ack_time_status, 1'b1);
				cycles(4);
				check("held", scl_oe_n, 1'b0);
				cfg.ack_data_value = nack;
				sw('{irq_clear: 1'b1, default: '0});
				sw('{release_set: 1'b1, default: '0});
			end
		join
		cycles(8);
		check("ack", a, nack);
		check("irq9", serial_irq_flag, !nack);
		check("stretch", clock_release, nack);
		if (!nack)
		begin
			check("buf", data_buffer, d);
			sw('{buf_read: 1'b1, irq_clear: 1'b1, default: '0});
			check("bf_clear", buffer_full, 1'b0);
			sw('{release_set: 1'b1, default: '0});
		end
	end
	endtask
	task automatic read_addr;
	begin
		m.start();
		m.xfer(8'h55, 1'b1, q, a);
		cycles(8);
		check("addr_ack", a, 1'b0);
		check("rw", read_write_status, 1'b1);
		check("addr_buf", data_buffer, 8'h55);
		check("ckp", clock_release, 1'b0);
		check("scl_held", scl_oe_n, 1'b0);
		sw('{buf_read: 1'b1, irq_clear: 1'b1, default: '0});
	end
	endtask
	task automatic tx_byte(input logic [7:0] d, input logic nack);
	begin
		sw('{buf_write: 1'b1, buf_wdata: d, default: '0});
		check("bf_load", buffer_full, 1'b1);
		sw('{release_set: 1'b1, default: '0});
		m.xfer(8'hff, nack, q, a);
		cycles(8);
		check("tx_data", q, d);
		check("ack_received_status", ack_received_status, nack);
		check("irq9", serial_irq_flag, 1'b1);
		check("hold9", scl_oe_n, nack);
		sw('{irq_clear: 1'b1, default: '0});
	end
	endtask
	task automatic test_hold_rx;
	begin
		cfg = '{address_hold_enable: 1'b1, data_hold_enable: 1'b1,
			stretch_enable: 1'b1, default: '0};
		m.start();
		hold_byte(8'h54, 1'b0);
		hold_byte(8'hc3, 1'b1);
		m.stop();
		check("stop", stop_seen, 1'b1);
		$display("test_hold_rx done");
	end
	endtask
	task automatic test_tx;
	begin
		cfg = '0;
		read_addr();
		tx_byte(8'ha5, 1'b0);
		tx_byte(8'h3c, 1'b1);
		m.stop();
		$display("test_tx done");
	end
	endtask
	task automatic test_collision;
	begin
		cfg = '{slave_collision_detect_enable: 1'b1, default: '0};
		read_addr();
		sw('{buf_write: 1'b1, buf_wdata: 8'h80, default: '0});
		sw('{release_set: 1'b1, default: '0});
		m.xfer(8'h00, 1'b1, q, a);
		cycles(4);
		check("bcol", bus_collision_flag, 1'b1);
		check("sda_free", sda_oe_n, 1'b1);
		sw('{bcol_clear: 1'b1, irq_clear: 1'b1, buf_read: 1'b1,
			default: '0});
		m.stop();
		$display("test_collision done");
	end
	endtask
	task automatic test_overflow;
	begin
		cfg = '0;
		m.start();
		m.xfer(8'h54, 1'b1, q, a);
		m.xfer(8'h11, 1'b1, q, a);
		cycles(8);
		check("ovf_nack", a, 1'b1);
		check("ovf", receive_overflow, 1'b1);
		check("ovf_buf", data_buffer, 8'h54);
		check("dna", data_not_address, 1'b1);
		check("start_seen", start_seen, 1'b1);
		sw('{buf_read: 1'b1, ovf_clear: 1'b1, irq_clear: 1'b1,
			default: '0});
		check("ovf_clr", receive_overflow, 1'b0);
		m.stop();
		check("stop_ovf", stop_seen, 1'b1);
		check("start_clr", start_seen, 1'b0);
		$display("test_overflow done");
	end
	endtask
	task automatic test_ten_bit;
	begin
		cfg = '{ten_bit_mode: 1'b1, default: '0};
		sw('{addr_write: 1'b1, addr_wdata: 8'hf6, default: '0});
		m.start();
		m.xfer(8'hf6, 1'b1, q, a);
		cycles(8);
		check("hi_ack", a, 1'b0);
		check("ua", update_address_flag, 1'b1);
		check("irq", serial_irq_flag, 1'b1);
		check("ua_hold", scl_oe_n, 1'b0);
		sw('{buf_read: 1'b1, irq_clear: 1'b1, default: '0});
		sw('{addr_write: 1'b1, addr_wdata: 8'h35, default: '0});
		check("ua_clr", update_address_flag, 1'b0);
		m.xfer(8'h34, 1'b1, q, a);
		cycles(8);
		check("lo_nack", a, 1'b1);
		check("ua_lo", update_address_flag, 1'b1);
		check("irq_lo", serial_irq_flag, 1'b1);
		check("bf_lo", buffer_full, 1'b0);
		check("ckp_lo", clock_release, 1'b1);
		sw('{addr_write: 1'b1, addr_wdata: 8'hf6, irq_clear: 1'b1,
			default: '0});
		m.stop();
		$display("test_ten_bit done");
	end
	endtask
	// ****
	// Run
	// ****
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial
	begin
		#1000000;
		num_errors++;
		finish_test();
	end
	initial
	begin
		sys_rst = 1'b1;
		ctrl = '0;
		cfg = '0;
		repeat (12) @(posedge sys_clk);
		#5 sys_rst = 1'b0;
		sw('{addr_write: 1'b1, addr_wdata: 8'h54, default: '0});
		test_hold_rx();
		test_tx();
		test_collision();
		test_overflow();
		test_ten_bit();
		finish_test();
	end
endmodule
bind i2c_slave_hold i2c_slave_hold_assertions chk
(
	.sys_clk, .sys_rst, .scl_in, .scl_oe_n, .sda_oe_n, .ctrl,
	.own_address_reg, .serial_irq_flag, .clock_release, .buffer_full,
	.update_address_flag, .bus_collision_flag
);
